//--- hdl/cdp_console_port.sv
// Console debug mode sequencer of the processor
//
// Behaviour
// - Request low two machine cycles enters console after current instruction completes.
// - While request low, loop three cycles, one reading command location 8402.
// - Command not executed while request low; executed once request goes high.
// - Breakpoint enters console and processes the held command immediately.
// - Request entry checks the internal copy of the configuration.
// - Breakpoint entry checks the system configuration word afresh.
// - No console configured: request ignored, breakpoint acts as no-operation.
// - Both interval timers halt while in console mode.
// - Command at 8402, operand at C000, result at 4000.
// - IO addresses C001 and 4001 enabled in console mode, never used.
// - XIO commands with external read do one extra harmless operand read.
// - After commands other than continue and suspend, halt until a new request falling edge.
// - Continue leaves console and resumes at the instruction after entry point.
// - Request low again during continue window gives exactly one instruction step.
// - Temporaries keep the instruction counter over console; writes may upset it.
// - Codes 0 to 4: continue, read reg, write reg, fault read-clear, status.
// - Register select in low 12 bits: GPR, temporaries, alternate, counter.
// - Codes 5-8 access memory at alternate address, 7 and 8 increment first.
// - Codes 9, A do XIO, A increments; B suspends; others ignored.
`timescale 1ns/1ns
`default_nettype none
module cdp_console_port (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic console_request_n,
	input wire logic cfgConsole,
	input wire logic sysCfgConsole,
	input wire logic instrDone,
	input wire logic bptExec,
	input wire logic [15:0] entryIc,
	input wire logic irqPending,
	output logic consoleMode,
	output logic timerHalt,
	output logic ioSpaceEnable,
	output logic bptNop,
	output logic resumeReq,
	output logic [15:0] resumeIc,
	output logic ioStrobe,
	output logic ioWrite,
	output logic [15:0] ioAddr,
	output logic [15:0] ioWdata,
	input wire logic [15:0] ioRdata,
	output logic coreReq,
	output var cdp_pkg::cdp_op_t coreOp,
	output logic [3:0] coreSel,
	output logic [15:0] coreAddr,
	output logic [15:0] coreWdata,
	input wire logic coreAck,
	input wire logic [15:0] coreRdata,
	input wire logic xioIllegal,
	input wire logic xioIsRead
);
	logic rstMeta_b;
	logic rstSync_b;
	logic reqLow;
	logic reqLow2;
	logic reqFall;
	cdp_pkg::cdp_state_t state, next_state;
	logic [15:0] cmd, next_cmd;
	logic [15:0] operand, next_operand;
	logic [15:0] altAddr, next_altAddr;
	logic [15:0] result, next_result;
	logic pendReq, next_pendReq;
	logic xioExtra, next_xioExtra;
	logic next_consoleMode, next_bptNop, next_resumeReq, next_ioStrobe, next_ioWrite;
	logic [15:0] next_resumeIc, next_ioAddr, next_ioWdata, next_coreAddr, next_coreWdata;
	logic next_coreReq;
	cdp_pkg::cdp_op_t next_coreOp;
	logic [3:0] next_coreSel;
	logic [3:0] code;
	logic [11:0] sel;

	cdp_tmp_if tmpBus ();

	// ==========================================================
	// Reset release
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_b <= 1'b0;
			rstSync_b <= 1'b0;
		end else begin
			rstMeta_b <= 1'b1;
			rstSync_b <= rstMeta_b;
		end
	end

	cdp_req_sync reqSync (
		.mclk(mclk),
		.rstSync_b(rstSync_b),
		.reqPin_n(console_request_n),
		.reqLow(reqLow),
		.reqLow2(reqLow2),
		.reqFall(reqFall)
	);

	cdp_temp_mem tempMem (
		.mclk(mclk),
		.rstSync_b(rstSync_b),
		.tmp(tmpBus.mem)
	);

	assign code = cmd[15:12];
	assign sel = cmd[11:0];
	assign timerHalt = consoleMode;
	// Status and clear locations are only enabled; nothing here issues them
	assign ioSpaceEnable = consoleMode;

	// ==========================================================
	// Sequencer next state
	always_comb begin
		next_state = state;
		next_cmd = cmd;
		next_operand = operand;
		next_altAddr = altAddr;
		next_result = result;
		next_pendReq = pendReq;
		next_xioExtra = xioExtra;
		next_bptNop = 1'b0;
		next_resumeReq = 1'b0;
		next_resumeIc = resumeIc;
		next_ioStrobe = 1'b0;
		next_ioWrite = 1'b0;
		next_ioAddr = ioAddr;
		next_ioWdata = ioWdata;
		next_coreReq = coreReq;
		next_coreOp = coreOp;
		next_coreSel = coreSel;
		next_coreAddr = coreAddr;
		next_coreWdata = coreWdata;
		tmpBus.we = 1'b0;
		tmpBus.waddr = cdp_pkg::TMP_IC_IDX;
		tmpBus.wdata = entryIc;
		tmpBus.raddr = cdp_pkg::TMP_IC_IDX;
		case (state)
			cdp_pkg::ST_NORMAL: begin
				// Request sampled against the internal configuration copy
				if (reqLow2 && cfgConsole) begin
					next_pendReq = 1'b1;
				end
				if (bptExec) begin
					if (sysCfgConsole) begin
						tmpBus.we = 1'b1;
						next_pendReq = 1'b0;
						next_xioExtra = 1'b0;
						next_ioStrobe = 1'b1;
						next_ioAddr = cdp_pkg::ADDR_CMD;
						next_state = cdp_pkg::ST_LOOP_A;
					end else begin
						next_bptNop = 1'b1;
					end
				end else if (instrDone && pendReq) begin
					// A step request landing during the refill is taken here
					tmpBus.we = 1'b1;
					next_pendReq = 1'b0;
					next_xioExtra = 1'b0;
					next_ioStrobe = 1'b1;
					next_ioAddr = cdp_pkg::ADDR_CMD;
					next_state = cdp_pkg::ST_LOOP_A;
				end
			end
			cdp_pkg::ST_LOOP_A: begin
				next_state = cdp_pkg::ST_LOOP_B;
			end
			cdp_pkg::ST_LOOP_B: begin
				next_cmd = ioRdata;
				next_state = cdp_pkg::ST_LOOP_C;
			end
			cdp_pkg::ST_LOOP_C: begin
				if (reqLow) begin
					next_ioStrobe = 1'b1;
					next_ioAddr = cdp_pkg::ADDR_CMD;
					next_state = cdp_pkg::ST_LOOP_A;
				end else begin
					next_state = cdp_pkg::ST_EXEC;
				end
			end
			cdp_pkg::ST_EXEC: begin
				if (code == cdp_pkg::CMD_NMEMRD || code == cdp_pkg::CMD_NMEMWR
						|| code == cdp_pkg::CMD_NXIO) begin
					next_altAddr = altAddr + 16'h0001;
				end
				if (code == cdp_pkg::CMD_CONT) begin
					next_state = cdp_pkg::ST_RESUME;
				end else if (cdp_pkg::cdp_needs_operand(code)) begin
					next_ioStrobe = 1'b1;
					next_ioAddr = cdp_pkg::ADDR_DIN;
					next_state = cdp_pkg::ST_OPND_A;
				end else begin
					next_state = cdp_pkg::ST_DO;
				end
			end
			cdp_pkg::ST_OPND_A: begin
				next_state = cdp_pkg::ST_OPND_B;
			end
			cdp_pkg::ST_OPND_B: begin
				// Extra read after a read XIO is discarded
				if (xioExtra) begin
					next_xioExtra = 1'b0;
					next_state = cdp_pkg::ST_OUT_SET;
				end else begin
					next_operand = ioRdata;
					next_state = cdp_pkg::ST_DO;
				end
			end
			cdp_pkg::ST_DO: begin
				next_state = cdp_pkg::ST_HALT;
				next_coreSel = sel[3:0];
				next_coreAddr = altAddr;
				next_coreWdata = operand;
				case (code)
					cdp_pkg::CMD_RDREG: begin
						if (sel <= cdp_pkg::SEL_GPR_HI) begin
							next_coreReq = 1'b1;
							next_coreOp = cdp_pkg::OP_RDREG;
							next_state = cdp_pkg::ST_CORE;
						end else if (cdp_pkg::cdp_is_tmp(sel)) begin
							tmpBus.raddr = sel[3:0];
							next_state = cdp_pkg::ST_TMPRD;
						end else if (sel == cdp_pkg::SEL_ALT) begin
							next_result = altAddr;
							next_state = cdp_pkg::ST_OUT_SET;
						end else if (sel == cdp_pkg::SEL_IC) begin
							next_state = cdp_pkg::ST_TMPRD;
						end
					end
					cdp_pkg::CMD_WRREG: begin
						if (sel <= cdp_pkg::SEL_GPR_HI) begin
							next_coreReq = 1'b1;
							next_coreOp = cdp_pkg::OP_WRREG;
							next_state = cdp_pkg::ST_CORE;
						end else if (cdp_pkg::cdp_is_tmp(sel)) begin
							// Overwrites saved state too; left to the user
							tmpBus.we = 1'b1;
							tmpBus.waddr = sel[3:0];
							tmpBus.wdata = operand;
						end else if (sel == cdp_pkg::SEL_ALT) begin
							next_altAddr = operand;
						end else if (sel == cdp_pkg::SEL_IC) begin
							tmpBus.we = 1'b1;
							tmpBus.wdata = operand;
						end
					end
					cdp_pkg::CMD_FAULT: begin
						next_coreReq = 1'b1;
						next_coreOp = cdp_pkg::OP_FAULT;
						next_state = cdp_pkg::ST_CORE;
					end
					cdp_pkg::CMD_WRSW: begin
						next_coreReq = 1'b1;
						next_coreOp = cdp_pkg::OP_WRSW;
						next_altAddr = cdp_pkg::ALT_AFTER_SW;
						next_state = cdp_pkg::ST_CORE;
					end
					cdp_pkg::CMD_MEMRD, cdp_pkg::CMD_NMEMRD: begin
						next_coreReq = 1'b1;
						next_coreOp = cdp_pkg::OP_MEMRD;
						next_state = cdp_pkg::ST_CORE;
					end
					cdp_pkg::CMD_MEMWR, cdp_pkg::CMD_NMEMWR: begin
						next_coreReq = 1'b1;
						next_coreOp = cdp_pkg::OP_MEMWR;
						next_state = cdp_pkg::ST_CORE;
					end
					cdp_pkg::CMD_XIO, cdp_pkg::CMD_NXIO: begin
						next_coreReq = 1'b1;
						next_coreOp = cdp_pkg::OP_XIO;
						next_state = cdp_pkg::ST_CORE;
					end
					cdp_pkg::CMD_DISABLE: begin
						next_state = cdp_pkg::ST_SUSP;
					end
					default: begin
						next_state = cdp_pkg::ST_HALT;
					end
				endcase
			end
			cdp_pkg::ST_CORE: begin
				if (coreAck) begin
					next_coreReq = 1'b0;
					next_result = coreRdata;
					next_state = cdp_pkg::ST_HALT;
					if (coreOp == cdp_pkg::OP_RDREG || coreOp == cdp_pkg::OP_FAULT
							|| coreOp == cdp_pkg::OP_MEMRD) begin
						next_state = cdp_pkg::ST_OUT_SET;
					end else if (coreOp == cdp_pkg::OP_XIO && !xioIllegal && xioIsRead) begin
						next_xioExtra = 1'b1;
						next_ioStrobe = 1'b1;
						next_ioAddr = cdp_pkg::ADDR_DIN;
						next_state = cdp_pkg::ST_OPND_A;
					end
				end
			end
			cdp_pkg::ST_TMPRD: begin
				next_result = tmpBus.rdata;
				next_state = cdp_pkg::ST_OUT_SET;
			end
			cdp_pkg::ST_OUT_SET: begin
				next_ioStrobe = 1'b1;
				next_ioWrite = 1'b1;
				next_ioAddr = cdp_pkg::ADDR_DOUT;
				next_ioWdata = result;
				next_state = cdp_pkg::ST_OUT_BUS;
			end
			cdp_pkg::ST_OUT_BUS: begin
				next_state = cdp_pkg::ST_HALT;
			end
			cdp_pkg::ST_HALT: begin
				if (reqFall) begin
					next_ioStrobe = 1'b1;
					next_ioAddr = cdp_pkg::ADDR_CMD;
					next_state = cdp_pkg::ST_LOOP_A;
				end
			end
			cdp_pkg::ST_SUSP: begin
				if (reqFall) begin
					next_ioStrobe = 1'b1;
					next_ioAddr = cdp_pkg::ADDR_CMD;
					next_state = cdp_pkg::ST_LOOP_A;
				end else if (irqPending) begin
					next_state = cdp_pkg::ST_RESUME;
				end
			end
			cdp_pkg::ST_RESUME: begin
				next_resumeReq = 1'b1;
				next_resumeIc = tmpBus.rdata;
				next_state = cdp_pkg::ST_NORMAL;
			end
			default: begin
				next_state = cdp_pkg::ST_NORMAL;
			end
		endcase
		next_consoleMode = (next_state != cdp_pkg::ST_NORMAL);
	end

	// ==========================================================
	// Sequencer registers
	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			state <= cdp_pkg::ST_NORMAL;
			cmd <= cdp_pkg::WORD_RESET;
			operand <= cdp_pkg::WORD_RESET;
			altAddr <= cdp_pkg::ALT_RESET;
			result <= cdp_pkg::WORD_RESET;
			pendReq <= 1'b0;
			xioExtra <= 1'b0;
			consoleMode <= 1'b0;
			bptNop <= 1'b0;
			resumeReq <= 1'b0;
			resumeIc <= cdp_pkg::WORD_RESET;
			ioStrobe <= 1'b0;
			ioWrite <= 1'b0;
			ioAddr <= cdp_pkg::WORD_RESET;
			ioWdata <= cdp_pkg::WORD_RESET;
			coreReq <= 1'b0;
			coreOp <= cdp_pkg::OP_RDREG;
			coreSel <= 4'h0;
			coreAddr <= cdp_pkg::WORD_RESET;
			coreWdata <= cdp_pkg::WORD_RESET;
		end else begin
			state <= next_state;
			cmd <= next_cmd;
			operand <= next_operand;
			altAddr <= next_altAddr;
			result <= next_result;
			pendReq <= next_pendReq;
			xioExtra <= next_xioExtra;
			consoleMode <= next_consoleMode;
			bptNop <= next_bptNop;
			resumeReq <= next_resumeReq;
			resumeIc <= next_resumeIc;
			ioStrobe <= next_ioStrobe;
			ioWrite <= next_ioWrite;
			ioAddr <= next_ioAddr;
			ioWdata <= next_ioWdata;
			coreReq <= next_coreReq;
			coreOp <= next_coreOp;
			coreSel <= next_coreSel;
			coreAddr <= next_coreAddr;
			coreWdata <= next_coreWdata;
		end
	end

	// ==========================================================
	// Checks
	default clocking cdpClk @(posedge mclk); endclocking
	default disable iff (!rstSync_b);

	a_entry_cause: assert property ($rose(consoleMode) |->
		$past(bptExec && sysCfgConsole) || $past(instrDone && pendReq))
		else $error("console entered without a qualified cause");
	a_req_inhibited: assert property (state == cdp_pkg::ST_NORMAL
		&& !cfgConsole && !pendReq |=> !pendReq)
		else $error("request taken while console not configured");
	a_bpt_as_nop: assert property (state == cdp_pkg::ST_NORMAL && bptExec
		&& !sysCfgConsole |=> bptNop && !consoleMode)
		else $error("breakpoint not treated as no-operation");
	a_poll_loop: assert property (state == cdp_pkg::ST_LOOP_A |->
		ioStrobe && !ioWrite && ioAddr == cdp_pkg::ADDR_CMD
		##1 state == cdp_pkg::ST_LOOP_B ##1 state == cdp_pkg::ST_LOOP_C)
		else $error("command poll loop broken");
	a_hold_while_low: assert property (state == cdp_pkg::ST_LOOP_C && reqLow
		|=> state == cdp_pkg::ST_LOOP_A)
		else $error("command executed while request low");
	a_exec_on_high: assert property (state == cdp_pkg::ST_LOOP_C && !reqLow
		|=> state == cdp_pkg::ST_EXEC)
		else $error("command not executed after request release");
	a_timer_halt: assert property (consoleMode |-> timerHalt && ioSpaceEnable
		&& state != cdp_pkg::ST_NORMAL || $past(state) == cdp_pkg::ST_RESUME)
		else $error("timers run in console mode");
	a_halt_wait: assert property (state == cdp_pkg::ST_HALT && !reqFall
		|=> state == cdp_pkg::ST_HALT && !ioStrobe)
		else $error("halt left without request falling edge");
	a_continue_exit: assert property (state == cdp_pkg::ST_EXEC
		&& code == cdp_pkg::CMD_CONT |=> ##1 resumeReq && !consoleMode
		&& resumeIc == $past(tmpBus.rdata))
		else $error("continue did not resume");
	a_incr_alt: assert property (state == cdp_pkg::ST_EXEC
		&& (code == cdp_pkg::CMD_NMEMRD || code == cdp_pkg::CMD_NXIO)
		|=> altAddr == $past(altAddr) + 16'h0001)
		else $error("alternate address not incremented");
	a_xio_extra: assert property (state == cdp_pkg::ST_CORE && coreAck
		&& coreOp == cdp_pkg::OP_XIO && !xioIllegal && xioIsRead
		|=> ioStrobe && ioAddr == cdp_pkg::ADDR_DIN)
		else $error("extra operand read missing after read XIO");
	a_sw_alt: assert property (state == cdp_pkg::ST_DO && code == cdp_pkg::CMD_WRSW
		|=> altAddr == cdp_pkg::ALT_AFTER_SW && coreOp == cdp_pkg::OP_WRSW)
		else $error("status write side effect wrong");

	c_req_entry: cover property (state == cdp_pkg::ST_NORMAL && instrDone && pendReq);
	c_bpt_entry: cover property (state == cdp_pkg::ST_NORMAL && bptExec && sysCfgConsole);
	c_continue: cover property (state == cdp_pkg::ST_RESUME);
	c_suspend_irq: cover property (state == cdp_pkg::ST_SUSP && irqPending && !reqFall);
endmodule : cdp_console_port
`default_nettype wire

//--- hdl/cdp_pkg.sv
// Shared constants, types and helpers for the console debug port
package cdp_pkg;

	// ==========================================================
	// Widths and depth
	localparam int DW = 16;
	localparam int TMP_AW = 4;
	localparam int TMP_DEPTH = 12;

	// ==========================================================
	// Fixed console locations in IO space
	localparam logic [15:0] ADDR_CMD = 16'h8402;
	localparam logic [15:0] ADDR_DIN = 16'hC000;
	localparam logic [15:0] ADDR_DOUT = 16'h4000;
	localparam logic [15:0] ADDR_STAT = 16'hC001;
	localparam logic [15:0] ADDR_CLR = 16'h4001;

	// ==========================================================
	// Command codes, held in the top four command bits
	localparam logic [3:0] CMD_CONT = 4'h0;
	localparam logic [3:0] CMD_RDREG = 4'h1;
	localparam logic [3:0] CMD_WRREG = 4'h2;
	localparam logic [3:0] CMD_FAULT = 4'h3;
	localparam logic [3:0] CMD_WRSW = 4'h4;
	localparam logic [3:0] CMD_MEMRD = 4'h5;
	localparam logic [3:0] CMD_MEMWR = 4'h6;
	localparam logic [3:0] CMD_NMEMRD = 4'h7;
	localparam logic [3:0] CMD_NMEMWR = 4'h8;
	localparam logic [3:0] CMD_XIO = 4'h9;
	localparam logic [3:0] CMD_NXIO = 4'hA;
	localparam logic [3:0] CMD_DISABLE = 4'hB;

	// ==========================================================
	// Register select, low twelve command bits
	localparam logic [11:0] SEL_GPR_HI = 12'h00F;
	localparam logic [11:0] SEL_TMP_LO = 12'h010;
	localparam logic [11:0] SEL_TMP_HI = 12'h01B;
	localparam logic [11:0] SEL_ALT = 12'h01C;
	localparam logic [11:0] SEL_IC = 12'h01D;

	// ==========================================================
	// Reset values and fixed figures
	localparam logic [15:0] ALT_RESET = 16'h0000;
	localparam logic [15:0] ALT_AFTER_SW = 16'h200E;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [3:0] TMP_IC_IDX = 4'h0;
	localparam logic [1:0] REQ_LOW_CYCLES = 2'h2;

	typedef enum {
		ST_NORMAL, ST_LOOP_A, ST_LOOP_B, ST_LOOP_C, ST_EXEC, ST_OPND_A, ST_OPND_B,
		ST_DO, ST_CORE, ST_TMPRD, ST_OUT_SET, ST_OUT_BUS, ST_HALT, ST_SUSP, ST_RESUME
	} cdp_state_t;

	typedef enum logic [2:0] {
		OP_RDREG, OP_WRREG, OP_FAULT, OP_WRSW, OP_MEMRD, OP_MEMWR, OP_XIO
	} cdp_op_t;

	function automatic logic cdp_is_tmp(input logic [11:0] sel);
		cdp_is_tmp = (sel >= SEL_TMP_LO) && (sel <= SEL_TMP_HI);
	endfunction : cdp_is_tmp

	function automatic logic cdp_needs_operand(input logic [3:0] code);
		cdp_needs_operand = (code == CMD_WRREG) || (code == CMD_WRSW) || (code == CMD_MEMWR)
			|| (code == CMD_NMEMWR) || (code == CMD_XIO) || (code == CMD_NXIO);
	endfunction : cdp_needs_operand

endpackage : cdp_pkg

//--- hdl/cdp_req_sync.sv
// Request pin synchroniser with level and falling edge detection
`timescale 1ns/1ns
`default_nettype none
module cdp_req_sync (
	input wire logic mclk,
	input wire logic rstSync_b,
	input wire logic reqPin_n,
	output logic reqLow,
	output logic reqLow2,
	output logic reqFall
);
	logic meta;
	logic sync;
	logic prev;
	logic [1:0] lowCnt;
	logic [1:0] next_lowCnt;

	// ==========================================================
	// Two-stage synchroniser; idle level is high
	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			meta <= 1'b1;
			sync <= 1'b1;
			prev <= 1'b1;
			lowCnt <= 2'h0;
		end else begin
			meta <= reqPin_n;
			sync <= meta;
			prev <= sync;
			lowCnt <= next_lowCnt;
		end
	end

	// Saturating count of low cycles after synchronisation
	always_comb begin
		next_lowCnt = lowCnt;
		if (sync) begin
			next_lowCnt = 2'h0;
		end else if (lowCnt < cdp_pkg::REQ_LOW_CYCLES) begin
			next_lowCnt = lowCnt + 2'h1;
		end
	end

	assign reqLow = !sync;
	assign reqLow2 = !sync && (lowCnt >= cdp_pkg::REQ_LOW_CYCLES - 2'h1);
	assign reqFall = prev && !sync;
endmodule : cdp_req_sync
`default_nettype wire

//--- hdl/cdp_temp_mem.sv
// Microcode temporaries store with registered read data
`timescale 1ns/1ns
`default_nettype none
module cdp_temp_mem (
	input wire logic mclk,
	input wire logic rstSync_b,
	cdp_tmp_if.mem tmp
);
	logic [15:0] store [cdp_pkg::TMP_DEPTH];
	logic [15:0] next_rdata;

	// ==========================================================
	// Write port; no reset so it maps onto plain storage
	always_ff @(posedge mclk) begin
		if (tmp.we && (tmp.waddr < 4'(cdp_pkg::TMP_DEPTH))) begin
			store[tmp.waddr] <= tmp.wdata;
		end
	end

	// ==========================================================
	// Read port, one cycle latency
	always_comb begin
		next_rdata = cdp_pkg::WORD_RESET;
		if (tmp.raddr < 4'(cdp_pkg::TMP_DEPTH)) begin
			next_rdata = store[tmp.raddr];
		end
	end

	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			tmp.rdata <= cdp_pkg::WORD_RESET;
		end else begin
			tmp.rdata <= next_rdata;
		end
	end
endmodule : cdp_temp_mem
`default_nettype wire

//--- hdl/cdp_tmp_if.sv
// Port bundle between the console sequencer and its temporaries store
`timescale 1ns/1ns
`default_nettype none
interface cdp_tmp_if;
	logic we;
	logic [3:0] waddr;
	logic [15:0] wdata;
	logic [3:0] raddr;
	logic [15:0] rdata;
	modport user (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : cdp_tmp_if
`default_nettype wire

//--- verification/cdp_console_model.sv
// Console controller model: command, operand and result locations
`timescale 1ns/1ns
`default_nettype none
module cdp_console_model (
	input wire logic mclk,
	input wire logic ioStrobe,
	input wire logic ioWrite,
	input wire logic [15:0] ioAddr,
	input wire logic [15:0] ioWdata,
	input wire logic [15:0] cmdWord,
	input wire logic [15:0] dinWord,
	output logic [15:0] ioRdata,
	output logic [15:0] lastOut,
	output int nCmdRd,
	output int nDinRd,
	output int nOut,
	output int nOdd
);
	logic st;
	logic wr;
	logic [15:0] ad;
	logic [15:0] wd;
	initial begin
		ioRdata = 16'h0000;
		lastOut = 16'h0000;
		nCmdRd = 0;
		nDinRd = 0;
		nOut = 0;
		nOdd = 0;
	end
	always @(posedge mclk) begin
		st = ioStrobe;
		wr = ioWrite;
		ad = ioAddr;
		wd = ioWdata;
		#1;
		// Changes every cycle so a stale word never passes for an answer
		ioRdata = ~ioRdata;
		if (st && wr && ad == cdp_pkg::ADDR_DOUT) begin
			lastOut = wd;
			nOut++;
		end else if (st && !wr && ad == cdp_pkg::ADDR_CMD) begin
			ioRdata = cmdWord;
			nCmdRd++;
		end else if (st && !wr && ad == cdp_pkg::ADDR_DIN) begin
			ioRdata = dinWord;
			nDinRd++;
		end else if (st) begin
			nOdd++;
		end
	end
endmodule : cdp_console_model
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the console debug port
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin nFail++; \
	$display("unexpected t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
	logic mclk, rst_b, console_request_n, cfgConsole, sysCfgConsole, instrDone, bptExec;
	logic irqPending, consoleMode, timerHalt, ioSpaceEnable, bptNop, resumeReq, ioStrobe;
	logic ioWrite, coreReq, coreAck, xioIllegal, xioIsRead, req, ack;
	logic [15:0] entryIc, resumeIc, ioAddr, ioWdata, ioRdata, coreAddr, coreWdata, coreRdata;
	logic [15:0] cmdWord, dinWord, lastOut, lastAddr, lastWdata, lastRd, ic, alt, d;
	logic [3:0] coreSel, lastSel;
	cdp_pkg::cdp_op_t coreOp, lastOp;
	int nFail, checked, nCmdRd, nDinRd, nOut, nOdd, nAck, nNop, nRes, tick, k, w;
	cdp_console_port dut (.mclk, .rst_b, .console_request_n, .cfgConsole, .sysCfgConsole,
		.instrDone, .bptExec, .entryIc, .irqPending, .consoleMode, .timerHalt, .ioSpaceEnable,
		.bptNop, .resumeReq, .resumeIc, .ioStrobe, .ioWrite, .ioAddr, .ioWdata, .ioRdata,
		.coreReq, .coreOp, .coreSel, .coreAddr, .coreWdata, .coreAck, .coreRdata,
		.xioIllegal, .xioIsRead);
	cdp_console_model model (.mclk, .ioStrobe, .ioWrite, .ioAddr, .ioWdata, .cmdWord,
		.dinWord, .ioRdata, .lastOut, .nCmdRd, .nDinRd, .nOut, .nOdd);
	initial begin
		mclk = 0;
		forever #25 mclk = ~mclk;
	end
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, nFail);
		if (nFail == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run
	// Core side: acknowledges after a random wait of zero to two cycles
	always @(posedge mclk) begin
		req = coreReq;
		ack = coreAck;
		nNop += bptNop;
		nRes += resumeReq;
		tick++;
		#1;
		if (tick == 4000) begin
			nFail++;
			complete_run();
		end
		if (ack) begin
			coreAck = 0;
		end else if (req && w > 0) begin
			w--;
		end else if (req) begin
			coreAck = 1;
			coreRdata = $urandom;
			lastRd = coreRdata;
			lastOp = coreOp;
			lastSel = coreSel;
			lastAddr = coreAddr;
			lastWdata = coreWdata;
			nAck++;
			w = $urandom % 3;
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc
	task automatic pulse(ref logic s);
		s = 1;
		cyc(1);
		s = 0;
	endtask : pulse
	task automatic enter();
		console_request_n = 0;
		cyc(4);
		entryIc = $urandom;
		ic = entryIc;
		pulse(instrDone);
		cyc(2);
	endtask : enter
	task automatic issue(input logic [15:0] cmd, input logic [15:0] din);
		console_request_n = 0;
		cyc(4);
		cmdWord = cmd;
		dinWord = din;
		cyc(4);
		console_request_n = 1;
		cyc(30);
	endtask : issue
	initial begin
		void'($urandom(32'h0da2));
		{rst_b, instrDone, bptExec, irqPending, coreAck, xioIllegal, xioIsRead} = '0;
		{console_request_n, cfgConsole, sysCfgConsole} = 3'b111;
		{entryIc, coreRdata, cmdWord, dinWord} = '0;
		{nFail, checked, nAck, nNop, nRes, tick, w} = '0;
		cyc(2);
		rst_b = 1;
		cyc(4);
		cfgConsole = 0;
		console_request_n = 0;
		cyc(4);
		pulse(instrDone);
		cyc(3);
		`CHK(consoleMode, 1'b0);
		console_request_n = 1;
		sysCfgConsole = 0;
		pulse(bptExec);
		cyc(2);
		`CHK(nNop, 1);
		// Enabled only once the pin is high, so no stale request is pending
		cfgConsole = 1;
		sysCfgConsole = 1;
		enter();
		`CHK(consoleMode, 1'b1);
		`CHK(timerHalt, 1'b1);
		`CHK(ioSpaceEnable, 1'b1);
		k = nCmdRd;
		cyc(12);
		`CHK(nCmdRd - k, 4);
		`CHK(nAck, 0);
		alt = $urandom;
		issue({cdp_pkg::CMD_WRREG, cdp_pkg::SEL_ALT}, alt);
		issue({cdp_pkg::CMD_RDREG, cdp_pkg::SEL_ALT}, 16'h0000);
		`CHK(lastOut, alt);
		issue({cdp_pkg::CMD_NMEMRD, 12'h000}, 16'h0000);
		alt++;
		`CHK(lastAddr, alt);
		`CHK(lastOut, lastRd);
		d = $urandom;
		issue({cdp_pkg::CMD_MEMWR, 12'h000}, d);
		`CHK(lastOp, cdp_pkg::OP_MEMWR);
		`CHK(lastWdata, d);
		for (int i = 0; i < 3; i++) begin
			d = $urandom;
			issue({cdp_pkg::CMD_RDREG, 8'h00, d[3:0]}, 16'h0000);
			`CHK(lastSel, d[3:0]);
			`CHK(lastOut, lastRd);
		end
		issue({cdp_pkg::CMD_FAULT, 12'h000}, 16'h0000);
		`CHK(lastOp, cdp_pkg::OP_FAULT);
		xioIsRead = 1;
		k = nDinRd;
		issue({cdp_pkg::CMD_XIO, 12'h000}, d);
		`CHK(lastAddr, alt);
		`CHK(nDinRd - k, 2);
		`CHK(lastOut, lastRd);
		xioIsRead = 0;
		issue({cdp_pkg::CMD_NXIO, 12'h000}, d);
		`CHK(lastAddr, alt + 16'h0001);
		{xioIllegal, xioIsRead} = 2'b11;
		k = nOut;
		issue({cdp_pkg::CMD_XIO, 12'h000}, d);
		`CHK(nOut, k);
		{xioIllegal, xioIsRead} = 2'b00;
		k = nAck + nOut;
		issue(16'hd000, 16'h0000);
		`CHK(nAck + nOut, k);
		k = nCmdRd;
		cyc(20);
		`CHK(nCmdRd, k);
		issue({cdp_pkg::CMD_WRSW, 12'h000}, d);
		`CHK(lastWdata, d);
		issue({cdp_pkg::CMD_RDREG, cdp_pkg::SEL_ALT}, 16'h0000);
		`CHK(lastOut, cdp_pkg::ALT_AFTER_SW);
		issue({cdp_pkg::CMD_RDREG, cdp_pkg::SEL_IC}, 16'h0000);
		`CHK(lastOut, ic);
		`CHK(nOdd, 0);
		issue(16'h0000, 16'h0000);
		`CHK(consoleMode, 1'b0);
		`CHK(resumeIc, ic);
		`CHK(nRes, 1);
		enter();
		`CHK(consoleMode, 1'b1);
		issue({cdp_pkg::CMD_DISABLE, 12'h000}, 16'h0000);
		pulse(irqPending);
		cyc(6);
		`CHK(consoleMode, 1'b0);
		`CHK(nRes, 2);
		// Command already in place before the breakpoint
		cmdWord = {cdp_pkg::CMD_RDREG, cdp_pkg::SEL_IC};
		entryIc = $urandom;
		ic = entryIc;
		pulse(bptExec);
		cyc(20);
		`CHK(lastOut, ic);
		issue(16'h0000, 16'h0000);
		`CHK(timerHalt, 1'b0);
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
